// ==== shared/lsc_pkg.sv ====
// constants and carrier types for the light sensor conversion block
package lsc_pkg;
  // register indices
  localparam logic [2:0] REG_CMD    = 3'h0;
  localparam logic [2:0] REG_CTL    = 3'h1;
  localparam logic [2:0] REG_HI     = 3'h2;
  localparam logic [2:0] REG_LO     = 3'h3;
  localparam logic [2:0] REG_RES_L  = 3'h4;
  localparam logic [2:0] REG_RES_H  = 3'h5;
  localparam logic [2:0] REG_TIM_L  = 3'h6;
  localparam logic [2:0] REG_TIM_H  = 3'h7;
  // command fields
  localparam int CMD_ENABLE_BIT = 7;
  localparam int CMD_SLEEP_BIT  = 6;
  localparam int CMD_TIMING_BIT = 5;
  localparam int CMD_DIODE_LSB  = 2;
  localparam int CMD_WIDTH_LSB  = 0;
  localparam logic [7:0] CMD_WR_MASK = 8'hef;
  // control fields
  localparam int CTL_FLAG_BIT    = 5;
  localparam int CTL_GAIN_LSB    = 2;
  localparam int CTL_PERSIST_LSB = 0;
  localparam logic [7:0] CTL_WR_MASK = 8'h0f;
  // pointer byte special bits
  localparam int PTR_SYNC_BIT  = 7;
  localparam int PTR_CLEAR_BIT = 6;
  // reset values
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] HI_RESET  = 8'hff;
  localparam logic [7:0] LO_RESET  = 8'h00;
  // diode select codes
  localparam logic [1:0] FIRST_DIODE_ONLY  = 2'h0;
  localparam logic [1:0] SECOND_DIODE_ONLY = 2'h1;
  localparam logic [1:0] DIODE_DIFFERENCE  = 2'h2;
  localparam logic [1:0] DIODE_NOP         = 2'h3;
  // integration cycles per width code
  localparam logic [16:0] WIDTH_CYC0 = 17'h10000;
  localparam logic [16:0] WIDTH_CYC1 = 17'h01000;
  localparam logic [16:0] WIDTH_CYC2 = 17'h00100;
  localparam logic [16:0] WIDTH_CYC3 = 17'h00010;
  // persistence counts per code
  localparam logic [4:0] PERSIST_M0 = 5'h01;
  localparam logic [4:0] PERSIST_M1 = 5'h04;
  localparam logic [4:0] PERSIST_M2 = 5'h08;
  localparam logic [4:0] PERSIST_M3 = 5'h10;
  // fixed bus address
  localparam logic [6:0] BUS_ADDR = 7'h44;
  // clock and integration oscillator rates
  localparam int CLK_KHZ      = 40000;
  localparam int OSC_SLOW_KHZ = 327;
  localparam int OSC_FAST_KHZ = 655;
  localparam logic [6:0] OSC_SLOW_DIV = 7'(CLK_KHZ / OSC_SLOW_KHZ);
  localparam logic [6:0] OSC_FAST_DIV = 7'(CLK_KHZ / OSC_FAST_KHZ);
  // one received byte from the bus
  typedef struct packed {
    logic       valid;
    logic       is_ptr;
    logic [2:0] addr;
    logic [7:0] data;
  } lsc_wr_t;
endpackage

// ==== verilog/lsc_i2c_slave.sv ====
// two-wire bus slave that turns bus traffic into register writes and reads
`timescale 1ns/1ps
module lsc_i2c_slave (
  // clock and reset
  input  wire logic          mclk_in,
  input  wire logic          srst_in,
  // bus pins
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output logic               sda_out,
  output logic               sda_oe_out,
  // register side
  input  wire logic [7:0]    rd_data_in,
  output logic [5:0]         ptr_out,
  output lsc_pkg::lsc_wr_t   wr_out
);
  import lsc_pkg::*;

  typedef enum {S_IDLE, S_ADDR, S_ACK, S_PTR, S_WDATA, S_RDATA} lsc_st_t;
  lsc_st_t     state;
  lsc_st_t     after_ack;
  logic [2:0]  scl_s;
  logic [2:0]  sda_s;
  logic [3:0]  cnt;
  logic [7:0]  shreg;
  logic        rw;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;

  // pins cross from outside: only stages 1 and 2 feed logic
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
    end
  end

  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign start_c  = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop_c   = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state      <= S_IDLE;
      after_ack  <= S_IDLE;
      cnt        <= 4'h0;
      shreg      <= 8'h00;
      rw         <= 1'b0;
      sda_out    <= 1'b0;
      sda_oe_out <= 1'b0;
      ptr_out    <= 6'h00;
      wr_out     <= '0;
    end else begin
      wr_out.valid <= 1'b0;
      if (start_c) begin
        state      <= S_ADDR;
        cnt        <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (stop_c) begin
        state      <= S_IDLE;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        if (state == S_RDATA) begin
          cnt <= cnt + 4'h1;
          if (cnt == 4'h8) begin
            rw <= ~sda_s[1];
          end
        end else if (state != S_IDLE && state != S_ACK && cnt < 4'h8) begin
          shreg <= {shreg[6:0], sda_s[1]};
          cnt   <= cnt + 4'h1;
        end
      end else if (scl_fall) begin
        case (state)
          S_ADDR: begin
            // only the hard-wired address is answered
            if (cnt == 4'h8 && shreg[7:1] == BUS_ADDR) begin
              rw         <= shreg[0];
              after_ack  <= shreg[0] ? S_RDATA : S_PTR;
              state      <= S_ACK;
              sda_oe_out <= 1'b1;
            end else if (cnt == 4'h8) begin
              state <= S_IDLE;
            end
          end
          S_PTR, S_WDATA: begin
            if (cnt == 4'h8) begin
              wr_out.valid  <= 1'b1;
              wr_out.is_ptr <= (state == S_PTR);
              wr_out.addr   <= ptr_out[2:0];
              wr_out.data   <= shreg;
              if (state == S_PTR) begin
                ptr_out <= shreg[5:0];
              end else begin
                ptr_out <= ptr_out + 6'h01;
              end
              after_ack  <= S_WDATA;
              state      <= S_ACK;
              sda_oe_out <= 1'b1;
            end
          end
          S_ACK: begin
            cnt   <= 4'h0;
            state <= after_ack;
            if (after_ack == S_RDATA) begin
              shreg      <= rd_data_in;
              ptr_out    <= ptr_out + 6'h01;
              sda_oe_out <= ~rd_data_in[7];
            end else begin
              sda_oe_out <= 1'b0;
            end
          end
          S_RDATA: begin
            if (cnt < 4'h8) begin
              sda_oe_out <= ~shreg[3'(7 - cnt)];
            end else if (cnt == 4'h8) begin
              sda_oe_out <= 1'b0;
            end else if (rw) begin
              // master acked: next byte follows
              cnt        <= 4'h0;
              shreg      <= rd_data_in;
              ptr_out    <= ptr_out + 6'h01;
              sda_oe_out <= ~rd_data_in[7];
            end else begin
              state <= S_IDLE;
            end
          end
          default: begin
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// ==== verilog/lsc_core.sv ====
// register file, integration timing, conversion and threshold interrupt
`timescale 1ns/1ps
// Behaviour
// - command bit 7 low holds the conversion core in reset; high runs it.
// - command bit 6 high drives the sleep pin and stops the conversion core; the bus stays active.
// - command bit 5 picks oscillator-timed or host-sync-timed integration.
// - bits 3:2 pick diode one, diode two, their signed difference, or none.
// - bits 1:0 pick 65536, 4096, 256 or 16 cycles per conversion.
// - control bit 5 reads the interrupt flag.
// - control bits 3:2 select one of four gain ranges for conversions.
// - flag and pin set after m outside readings in a row, m=1,4,8,16.
// - high threshold byte resets to ff, forms upper half of 16-bit limit.
// - low threshold byte resets to 00, forms upper half of 16-bit limit.
// - result readable at 04 low and 05 high, refreshed every integration.
// - in external timing a 16-bit timer counts each integration clock.
// - in external timing, timer count captured at each integration end with the result.
// - captured timer readable at 06 low and 07 high.
// - in external timing, pointer byte with bit 7 set ends and restarts integration.
// - pointer byte with bit 6 set clears flag and interrupt pin.
// - bus answers only its fixed seven-bit address.
module lsc_core (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  // bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  // analog front end
  input  wire logic [1:0]  diode_pulse_in,
  output logic             sleep_out,
  output logic [1:0]       gain_out,
  // open-drain interrupt pin
  output logic             int_n_out,
  output logic             int_n_oe_out
);
  import lsc_pkg::*;

  default clocking cb_core @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  lsc_wr_t      wr;
  logic [5:0]   ptr;
  logic [7:0]   rd_data;
  logic [7:0]   conversion_command;
  logic [7:0]   gain_interrupt_control;
  logic [7:0]   upper_limit_byte;
  logic [7:0]   lower_limit_byte;
  logic [15:0]  result;
  logic [15:0]  timer_count;
  logic [1:0]   pulse_s1;
  logic [1:0]   pulse_s2;
  logic [6:0]   div_cnt;
  logic         tick;
  logic [16:0]  cyc;
  logic [17:0]  acc;
  logic         flag;
  logic [4:0]   persist_cnt;
  logic         host_sync_pulse;
  logic         clear_pulse;
  logic         enable;
  logic         device_sleep_bit;
  logic         ext_mode;
  logic [1:0]   diode_sel;
  logic         active;
  logic [16:0]  width_cyc;
  logic [4:0]   persist_m;
  logic         conv_done;
  logic [17:0]  next_acc;
  logic [15:0]  next_result;
  logic [16:0]  lim;
  logic         outside;
  logic         flag_set;

  lsc_i2c_slave u_bus (
    .mclk_in    (mclk_in),
    .srst_in    (srst_in),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .sda_out    (sda_out),
    .sda_oe_out (sda_oe_out),
    .rd_data_in (rd_data),
    .ptr_out    (ptr),
    .wr_out     (wr)
  );

  assign enable           = conversion_command[CMD_ENABLE_BIT];
  assign device_sleep_bit = conversion_command[CMD_SLEEP_BIT];
  assign ext_mode         = conversion_command[CMD_TIMING_BIT];
  assign diode_sel        = conversion_command[CMD_DIODE_LSB +: 2];
  // no-op diode code leaves the core idle
  assign active = enable & ~device_sleep_bit & (diode_sel != DIODE_NOP);

  // pointer byte bits act as write-only strobes
  assign host_sync_pulse = wr.valid & wr.is_ptr & wr.data[PTR_SYNC_BIT];
  assign clear_pulse     = wr.valid & wr.is_ptr & wr.data[PTR_CLEAR_BIT];

  // register writes; unmapped pointers are dropped
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      conversion_command     <= CMD_RESET;
      gain_interrupt_control <= CTL_RESET;
      upper_limit_byte       <= HI_RESET;
      lower_limit_byte       <= LO_RESET;
    end else if (wr.valid && !wr.is_ptr && ptr[5:3] == 3'h0) begin
      if (wr.addr == REG_CMD) begin
        conversion_command <= wr.data & CMD_WR_MASK;
      end else if (wr.addr == REG_CTL) begin
        gain_interrupt_control <= wr.data & CTL_WR_MASK;
      end else if (wr.addr == REG_HI) begin
        upper_limit_byte <= wr.data;
      end else if (wr.addr == REG_LO) begin
        lower_limit_byte <= wr.data;
      end
    end
  end

  // read mux
  always_comb begin
    rd_data = 8'h00;
    if (ptr[5:3] != 3'h0) begin
      rd_data = 8'h00;
    end else if (ptr[2:0] == REG_CMD) begin
      rd_data = conversion_command;
    end else if (ptr[2:0] == REG_CTL) begin
      rd_data = gain_interrupt_control;
      rd_data[CTL_FLAG_BIT] = flag;
    end else if (ptr[2:0] == REG_HI) begin
      rd_data = upper_limit_byte;
    end else if (ptr[2:0] == REG_LO) begin
      rd_data = lower_limit_byte;
    end else if (ptr[2:0] == REG_RES_L) begin
      rd_data = result[7:0];
    end else if (ptr[2:0] == REG_RES_H) begin
      rd_data = result[15:8];
    end else if (ptr[2:0] == REG_TIM_L) begin
      rd_data = timer_count[7:0];
    end else begin
      rd_data = timer_count[15:8];
    end
  end

  // analog controls; power-down also shuts the oscillator below
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sleep_out <= 1'b0;
      gain_out  <= 2'h0;
    end else begin
      sleep_out <= device_sleep_bit;
      gain_out  <= gain_interrupt_control[CTL_GAIN_LSB +: 2];
    end
  end

  // comparator pulses come from the analog side
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pulse_s1 <= 2'h0;
      pulse_s2 <= 2'h0;
    end else begin
      pulse_s1 <= diode_pulse_in;
      pulse_s2 <= pulse_s1;
    end
  end

  // integration clock: upper two ranges run the oscillator twice as fast
  always_ff @(posedge mclk_in) begin
    if (srst_in || !active) begin
      div_cnt <= 7'h00;
    end else if (tick) begin
      div_cnt <= 7'h00;
    end else begin
      div_cnt <= div_cnt + 7'h01;
    end
  end
  assign tick = active & (div_cnt == (gain_out[1] ? OSC_FAST_DIV - 7'h01
                                                  : OSC_SLOW_DIV - 7'h01));

  always_comb begin
    case (conversion_command[CMD_WIDTH_LSB +: 2])
      2'h0:    width_cyc = WIDTH_CYC0;
      2'h1:    width_cyc = WIDTH_CYC1;
      2'h2:    width_cyc = WIDTH_CYC2;
      default: width_cyc = WIDTH_CYC3;
    endcase
  end

  // end of integration: cycle count or host sync
  assign conv_done = active & (ext_mode ? host_sync_pulse
                                        : tick & (cyc == width_cyc - 17'h1));

  // difference taken per tick instead of two passes: same result for
  // steady light at half the latency
  always_comb begin
    next_acc = acc;
    if (tick) begin
      if (diode_sel == SECOND_DIODE_ONLY) begin
        next_acc = acc + {17'h0, pulse_s2[1]};
      end else begin
        next_acc = acc + {17'h0, pulse_s2[0]};
        if (diode_sel == DIODE_DIFFERENCE) begin
          next_acc = next_acc - {17'h0, pulse_s2[1]};
        end
      end
    end
  end

  // saturate to n bits, or n-1 signed for the difference
  always_comb begin
    lim = ext_mode ? 17'h0ffff : width_cyc - 17'h1;
    next_result = next_acc[17] ? 16'h0000 : 16'hffff;
    if (diode_sel == DIODE_DIFFERENCE) begin
      lim = lim >> 1;
      if (!next_acc[17] && next_acc > {1'b0, lim}) begin
        next_result = lim[15:0];
      end else if (next_acc[17] && (~next_acc + 18'h1) > {1'b0, lim}) begin
        next_result = ~lim[15:0] + 16'h1;
      end else begin
        next_result = next_acc[15:0];
      end
    end else if (next_acc <= {1'b0, lim}) begin
      next_result = next_acc[15:0];
    end else begin
      next_result = lim[15:0];
    end
  end

  // core counters held clear while disabled
  always_ff @(posedge mclk_in) begin
    if (srst_in || !active) begin
      cyc <= 17'h0;
      acc <= 18'h0;
    end else if (conv_done) begin
      cyc <= 17'h0;
      acc <= 18'h0;
    end else if (tick) begin
      cyc <= cyc + 17'h1;
      acc <= next_acc;
    end
  end

  // result captured at each end, timer with it in external timing only
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      result      <= 16'h0000;
      timer_count <= 16'h0000;
    end else if (conv_done) begin
      result <= next_result;
      if (ext_mode) begin
        timer_count <= cyc[15:0];
      end
    end
  end

  always_comb begin
    case (gain_interrupt_control[CTL_PERSIST_LSB +: 2])
      2'h0:    persist_m = PERSIST_M0;
      2'h1:    persist_m = PERSIST_M1;
      2'h2:    persist_m = PERSIST_M2;
      default: persist_m = PERSIST_M3;
    endcase
  end

  // window test on the freshly completed reading
  assign outside = (next_result > {upper_limit_byte, 8'h00}) |
                   (next_result < {lower_limit_byte, 8'h00});
  // compare against m-1 so a saturated tally cannot wrap and block the set
  assign flag_set = conv_done & outside & (persist_cnt >= persist_m - 5'h1);

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      persist_cnt <= 5'h00;
    end else if (conv_done && !outside) begin
      persist_cnt <= 5'h00;
    end else if (conv_done && persist_cnt != 5'h1f) begin
      persist_cnt <= persist_cnt + 5'h1;
    end
  end

  // set beats a simultaneous clear so no event is lost
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      flag <= 1'b0;
    end else if (flag_set) begin
      flag <= 1'b1;
    end else if (clear_pulse) begin
      flag <= 1'b0;
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      int_n_out    <= 1'b0;
      int_n_oe_out <= 1'b0;
    end else begin
      int_n_out    <= 1'b0;
      int_n_oe_out <= flag_set | (flag & ~clear_pulse);
    end
  end

  AST_CORE_HELD: assert property (
    !enable |=> (cyc == 17'h0) && (acc == 18'h0))
    else $error("core counters run while disabled");

  AST_SLEEP_PIN: assert property (
    device_sleep_bit |=> sleep_out && !tick)
    else $error("power-down not applied");

  AST_INT_LENGTH: assert property (
    conv_done && !ext_mode |-> cyc == width_cyc - 17'h1)
    else $error("internal integration length wrong");

  AST_SYNC_END: assert property (
    active && ext_mode && host_sync_pulse |=> cyc == 17'h0)
    else $error("sync write did not restart integration");

  AST_NOP_IDLE: assert property (
    diode_sel == DIODE_NOP |-> !conv_done && !tick)
    else $error("conversion in no-op mode");

  AST_TIMER_CAP: assert property (
    conv_done && ext_mode |=> timer_count == $past(cyc[15:0]))
    else $error("timer count not captured");

  AST_RESULT_UPD: assert property (
    conv_done |=> result == $past(next_result))
    else $error("result not refreshed");

  AST_PERSIST: assert property (
    !flag && conv_done && outside && (persist_cnt < persist_m - 5'h1)
    |=> !flag)
    else $error("flag set before persistence count");

  AST_FLAG_SET: assert property (
    conv_done && outside && (persist_cnt >= persist_m - 5'h1)
    |=> flag && int_n_oe_out)
    else $error("flag not set after persistence count");

  AST_FLAG_HOLD: assert property (
    flag && !clear_pulse |=> flag && int_n_oe_out)
    else $error("flag dropped without clear");

  AST_CLEAR: assert property (
    clear_pulse && !flag_set |=> !flag && !int_n_oe_out)
    else $error("clear write ignored");

  AST_DEFAULTS: assert property (
    $fell(srst_in) |-> upper_limit_byte == HI_RESET
                       && lower_limit_byte == LO_RESET)
    else $error("threshold defaults wrong");
endmodule

// ==== bench/lsc_host.sv ====
// two-wire bus host model driving the block's register port
`timescale 1ns/1ps
module lsc_host (
  // clock
  input  wire logic clk_in,
  // bus pins
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  import lsc_pkg::*;
  logic ack;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    ack = 1'b0;
  end
  // ten cycles keeps each phase above the eight-cycle minimum
  task automatic hp();
    repeat (10) @(posedge clk_in);
  endtask
  task automatic sc(input logic v);
    scl_out <= v;
    hp();
  endtask
  // sda is moved a full phase apart from scl so no edge looks like a stop
  task automatic start();
    sda_low_out <= 1'b0;
    hp();
    sc(1'b1);
    sda_low_out <= 1'b1;
    hp();
    sc(1'b0);
  endtask
  task automatic stop();
    sda_low_out <= 1'b1;
    hp();
    sc(1'b1);
    sda_low_out <= 1'b0;
    hp();
  endtask
  task automatic bit_slot(input logic b, output logic s);
    sda_low_out <= ~b;
    hp();
    scl_out <= 1'b1;
    hp();
    s = sda_in;
    sc(1'b0);
  endtask
  task automatic send(input logic [7:0] v, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(v[i], s);
    bit_slot(1'b1, s);
    a = ~s;
  endtask
  task automatic recv(output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, s);
      v[i] = s;
    end
    bit_slot(1'b1, s);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d,
                    input logic only_ptr);
    start();
    send({BUS_ADDR, 1'b0}, ack);
    send(p, ack);
    if (!only_ptr) send(d, ack);
    stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    start();
    send({BUS_ADDR, 1'b0}, ack);
    send(p, ack);
    start();
    send({BUS_ADDR, 1'b1}, ack);
    recv(d);
    stop();
  endtask
endmodule

// ==== bench/lsc_core_bench.sv ====
// self-checking bench for the light sensor conversion block
`timescale 1ns/1ps
module lsc_core_bench;
  import lsc_pkg::*;
  logic       mclk, srst, scl, host_low, sda_oe, sda_o, int_n, int_oe, sleep;
  logic [1:0] diode, gain;
  logic [7:0] lf;
  int         fails, cmp_count, cyc;
  wire logic  sda = ~(host_low | (sda_oe & ~sda_o));
  lsc_host host (.clk_in(mclk), .sda_in(sda), .scl_out(scl),
                 .sda_low_out(host_low));
  lsc_core DUT (.mclk_in(mclk), .srst_in(srst), .scl_in(scl), .sda_in(sda),
                .sda_out(sda_o), .sda_oe_out(sda_oe), .diode_pulse_in(diode),
                .sleep_out(sleep), .gain_out(gain), .int_n_out(int_n),
                .int_n_oe_out(int_oe));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // reference result: one count per tick, clamped to the signed or full span
  function automatic logic [15:0] exp_res(input int m, input logic [1:0] d);
    int a;
    int b;
    a = d[0];
    b = d[1];
    if (m == 2) return 16'((a - b) * 7);
    return 16'(((m == 0) ? a : b) * 15);
  endfunction
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    host.rd(a, v[7:0]);
    host.rd(a + 8'h01, v[15:8]);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    logic [15:0] v;
    logic [15:0] r;
    logic [15:0] last;
    logic        a;
    int          c0;
    int          dv;
    logic [7:0]  rv [4];
    rv = '{8'h00, 8'h00, 8'hff, 8'h00};
    srst = 1'b1;
    diode = 2'h0;
    lf = 8'h61;
    fails = 0;
    cmp_count = 0;
    cyc = 0;
    v = 16'h0;
    wait_cyc(5);
    srst <= 1'b0;
    wait_cyc(3);
    for (int i = 0; i < 4; i++) begin
      host.rd(8'(i), v[7:0]);
      check("reset value", v, {8'h0, rv[i]});
    end
    check("pin drive", {14'h0, int_n, int_oe}, 16'h0);
    host.wr(8'h04, 8'h55, 1'b0);
    check("ack", {15'h0, host.ack}, 16'h1);
    host.rd(8'h04, v[7:0]);
    check("read only", v, 16'h0);
    host.rd(8'h08, v[7:0]);
    check("unmapped", v, 16'h0);
    host.start();
    host.send(8'h8a, a);
    host.stop();
    check("foreign ack", {15'h0, a}, 16'h0);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h00, 8'(i), 1'b0);
      host.wr(8'h01, 8'(i * 4), 1'b0);
      host.rd(8'h00, v[7:0]);
      check("width code", v, 16'(i));
      host.rd(8'h01, v[7:0]);
      check("gain code", v, 16'(i * 4));
      check("gain pin", {14'h0, gain}, 16'(i));
    end
    diode <= 2'h3;
    wait_cyc(1000);
    rd16(8'h04, r);
    check("disabled result", r, 16'h0);
    $display("test fields done");
    last = 16'h0;
    for (int m = 0; m < 4; m++) begin
      lf = lfsr(lf);
      diode <= lf[1:0];
      host.wr(8'h00, 8'(8'h83 | (m << 2)), 1'b0);
      wait_cyc(2000);
      rd16(8'h04, r);
      if (m < 3) last = exp_res(m, lf[1:0]);
      check("result", r, last);
    end
    rd16(8'h06, r);
    check("internal timer", r, 16'h0);
    $display("test conversion done");
    diode <= 2'h1;
    host.wr(8'h00, 8'h83, 1'b0);
    host.wr(8'h01, 8'h01, 1'b0);
    host.wr(8'h02, 8'h00, 1'b0);
    wait_cyc(2000);
    check("early pin", {15'h0, int_oe}, 16'h0);
    wait_cyc(8000);
    check("late pin", {15'h0, int_oe}, 16'h1);
    host.rd(8'h01, v[7:0]);
    check("flag", v, 16'h21);
    host.wr(8'h02, 8'hff, 1'b0);
    wait_cyc(4000);
    check("held pin", {15'h0, int_oe}, 16'h1);
    host.wr(8'h40, 8'h00, 1'b1);
    check("cleared pin", {15'h0, int_oe}, 16'h0);
    host.rd(8'h01, v[7:0]);
    check("cleared flag", v, 16'h01);
    host.wr(8'h01, 8'h00, 1'b0);
    host.wr(8'h03, 8'h01, 1'b0);
    wait_cyc(2500);
    check("low pin", {15'h0, int_oe}, 16'h1);
    host.wr(8'h03, 8'h00, 1'b0);
    host.wr(8'h40, 8'h00, 1'b1);
    check("low cleared", {15'h0, int_oe}, 16'h0);
    $display("test threshold done");
    host.wr(8'h00, 8'ha3, 1'b0);
    host.wr(8'h80, 8'h00, 1'b1);
    c0 = cyc;
    wait_cyc(6100);
    host.wr(8'h80, 8'h00, 1'b1);
    c0 = (cyc - c0) / 122;
    rd16(8'h06, r);
    dv = int'(r) - c0;
    check("timer", 16'(dv inside {[-1:1]}), 16'h1);
    rd16(8'h04, r);
    dv = int'(r) - c0;
    check("ext result", 16'(dv inside {[-1:1]}), 16'h1);
    $display("test external done");
    host.wr(8'h00, 8'h03, 1'b0);
    host.wr(8'h00, 8'h40, 1'b0);
    wait_cyc(2);
    check("sleep pin", {15'h0, sleep}, 16'h1);
    $display("test sleep done");
    stop_test();
  end
endmodule
